// File: core/cis_pkg.sv
// Shared constants, state codes and carrier structs of the interrupt sequencer
package cis_pkg;

    // ========================================
    // Flag image layout
    localparam int          TF_BIT     = 8;
    localparam int          IF_BIT     = 9;
    localparam int          OF_BIT     = 11;
    localparam logic [15:0] TF_MASK    = 16'h0100;
    localparam logic [15:0] ENTRY_CLR  = 16'h0300;
    localparam logic [15:0] FLAGS_RST  = 16'h0000;

    // ========================================
    // Fixed type codes and vector table
    localparam logic [7:0]  TYPE_DIV   = 8'h00;
    localparam logic [7:0]  TYPE_STEP  = 8'h01;
    localparam logic [7:0]  TYPE_NMI   = 8'h02;
    localparam logic [7:0]  TYPE_OVF   = 8'h04;
    localparam int          VEC_SHIFT  = 2;
    localparam logic [19:0] WORD_BYTES = 20'h00002;
    localparam logic [15:0] SP_STEP    = 16'h0002;
    localparam int          SEG_SHIFT  = 4;

    // ========================================
    // Request classes, highest priority at index 0
    localparam int          PRI_INT    = 0;
    localparam int          PRI_NMI    = 1;
    localparam int          PRI_MASKABLE_REQUEST_LINE   = 2;
    localparam int          PRI_STEP   = 3;
    localparam int          NUM_SRC    = 4;

    typedef enum logic [1:0] {
        CIS_OP_NONE = 2'h0,
        CIS_OP_ACK  = 2'h1,
        CIS_OP_RD   = 2'h2,
        CIS_OP_WR   = 2'h3
    } cis_op_t;

    typedef enum logic [3:0] {
        CIS_IDLE    = 4'h0,
        CIS_ACK1    = 4'h1,
        CIS_ACK2    = 4'h3,
        CIS_PUSH_F  = 4'h2,
        CIS_PUSH_CS = 4'h6,
        CIS_PUSH_IP = 4'h7,
        CIS_VEC_LO  = 4'h5,
        CIS_VEC_HI  = 4'h4,
        CIS_LOAD    = 4'hc,
        CIS_POP_IP  = 4'hd,
        CIS_POP_CS  = 4'hf,
        CIS_POP_FL  = 4'he
    } cis_state_t;

    // Instruction completion report from the execution unit
    typedef struct packed {
        logic        done;
        logic        prefix;
        logic        step_point;
        logic        seg_load;
        logic        enable_set_instr;
        logic        handler_return_instr;
        logic        soft_int;
        logic        into;
        logic        div_ovf;
        logic [7:0]  soft_type;
        logic [15:0] next_ip;
        logic [15:0] flags;
    } cis_retire_t;

    typedef struct packed {
        logic [15:0] cs;
        logic [15:0] ss;
        logic [15:0] sp;
    } cis_ctx_t;

    typedef struct packed {
        logic        load;
        logic [15:0] ip;
        logic [15:0] cs;
        logic [15:0] sp;
        logic [15:0] flags;
    } cis_redirect_t;

    typedef struct packed {
        cis_op_t     op;
        logic [19:0] addr;
        logic [15:0] wdata;
    } cis_bus_t;

endpackage

// File: core/cis_sync2.sv
// Two-flop level synchroniser for pin inputs
`timescale 1ns/1ps
module cis_sync2 import cis_pkg::*; #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_reg;

    // ========================================
    // First stage feeds only the second
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            meta_reg <= '0;
            dout     <= '0;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule

// File: core/cis_prio.sv
// Fixed priority picker, index 0 wins
`timescale 1ns/1ps
module cis_prio import cis_pkg::*; #(
    parameter int N = NUM_SRC
) (
    input  wire logic [N-1:0] req,
    output logic      [N-1:0] grant
);
    // ========================================
    // Lowest set bit isolated by two's complement
    always_comb begin
        grant = req & N'(~req + N'(1));
    end
endmodule

// File: core/cis_seq.sv
// Interrupt and exception sequencer of the core
`timescale 1ns/1ps
module cis_seq import cis_pkg::*; (
    input  wire logic          clk_sys,
    input  wire logic          reset_n,
    input  wire cis_retire_t   retire,
    input  wire cis_ctx_t      ctx,
    input  wire logic          maskable_request_line,
    input  wire logic          nmi_line,
    output logic               busy,
    output logic               bus_valid,
    output cis_bus_t           bus_cmd,
    input  wire logic          bus_done,
    input  wire logic [15:0]   bus_rdata,
    output cis_redirect_t      redirect
);

    // ========================================
    // Declarations
    cis_state_t         state_reg;
    logic [7:0]         type_reg;
    logic [15:0]        ip_reg;
    logic [15:0]        cs_reg;
    logic [15:0]        ss_reg;
    logic [15:0]        sp_reg;
    logic [15:0]        flags_reg;
    logic [15:0]        flags_push_reg;
    logic               ret_reg;
    logic               ack_mode_reg;
    logic               step_due_reg;
    logic               nmi_pend_reg;
    logic               nmi_prev_reg;
    logic               valid_reg;
    cis_bus_t           cmd_reg;
    cis_redirect_t      redir_reg;
    logic [1:0]         pins_s;
    logic               maskable_request_line_s;
    logic               nmi_s;
    logic               boundary;
    logic               full_end;
    logic               ext_ok;
    logic               ret_start;
    logic               into_hit;
    logic [NUM_SRC-1:0] reqs;
    logic [NUM_SRC-1:0] grant;
    logic               take;
    logic [7:0]         take_type;
    logic               adv;
    logic               need_bus;
    logic               nmi_clr;
    logic               chain_nmi;
    logic               go_idle;
    logic [19:0]        stack_addr;
    logic [19:0]        vec_addr;

    // ========================================
    // Pin synchronisers
    cis_sync2 #(
        .W (2)
    ) u_sync (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .din     ({nmi_line, maskable_request_line}),
        .dout    (pins_s)
    );

    assign maskable_request_line_s = pins_s[0];
    assign nmi_s  = pins_s[1];

    // ========================================
    // Non-maskable edge latch
    // Set wins over clear so an edge in the service cycle is kept
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            nmi_prev_reg <= 1'b0;
            nmi_pend_reg <= 1'b0;
        end else begin
            nmi_prev_reg <= nmi_s;
            if (nmi_s && !nmi_prev_reg) begin
                nmi_pend_reg <= 1'b1;
            end else if (nmi_clr) begin
                nmi_pend_reg <= 1'b0;
            end
        end
    end

    // ========================================
    // Recognition at instruction boundaries
    always_comb begin
        boundary  = retire.done && !retire.prefix && (state_reg == CIS_IDLE);
        full_end  = boundary && !retire.step_point;
        ext_ok    = boundary && !retire.seg_load;
        ret_start = full_end && retire.handler_return_instr;
        into_hit  = retire.into && retire.flags[OF_BIT];
        reqs[PRI_INT]  = full_end && !retire.handler_return_instr
                         && (retire.soft_int || into_hit || retire.div_ovf);
        reqs[PRI_NMI]  = ext_ok && !retire.handler_return_instr && nmi_pend_reg;
        reqs[PRI_MASKABLE_REQUEST_LINE] = ext_ok && !retire.handler_return_instr && maskable_request_line_s
                         && retire.flags[IF_BIT] && !retire.enable_set_instr;
        reqs[PRI_STEP] = full_end && !retire.handler_return_instr && !retire.seg_load
                         && flags_reg[TF_BIT];
    end

    cis_prio #(
        .N (NUM_SRC)
    ) u_prio (
        .req   (reqs),
        .grant (grant)
    );

    assign take = |reqs;

    always_comb begin
        take_type = TYPE_STEP;
        if (grant[PRI_INT]) begin
            if (retire.div_ovf) begin
                take_type = TYPE_DIV;
            end else if (retire.soft_int) begin
                take_type = retire.soft_type;
            end else begin
                take_type = TYPE_OVF;
            end
        end else if (grant[PRI_NMI]) begin
            take_type = TYPE_NMI;
        end
    end

    assign adv       = valid_reg && bus_done;
    assign chain_nmi = !ret_reg && nmi_pend_reg;
    assign go_idle   = ret_reg || (!nmi_pend_reg && !step_due_reg);
    assign nmi_clr   = (grant[PRI_NMI] && take)
                       || (state_reg == CIS_LOAD && chain_nmi);
    assign busy      = (state_reg != CIS_IDLE) || take || ret_start;

    // ========================================
    // Entry and return sequence
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_reg      <= CIS_IDLE;
            type_reg       <= 8'h00;
            ip_reg         <= 16'h0000;
            cs_reg         <= 16'h0000;
            ss_reg         <= 16'h0000;
            sp_reg         <= 16'h0000;
            flags_reg      <= FLAGS_RST;
            flags_push_reg <= FLAGS_RST;
            ret_reg        <= 1'b0;
            ack_mode_reg   <= 1'b0;
            step_due_reg   <= 1'b0;
        end else begin
            unique case (state_reg)
                CIS_IDLE: begin
                    if (retire.done) begin
                        flags_reg <= retire.flags;
                    end
                    if (ret_start) begin
                        ss_reg    <= ctx.ss;
                        sp_reg    <= ctx.sp;
                        ret_reg   <= 1'b1;
                        state_reg <= CIS_POP_IP;
                    end else if (take) begin
                        type_reg       <= take_type;
                        ip_reg         <= retire.next_ip;
                        cs_reg         <= ctx.cs;
                        ss_reg         <= ctx.ss;
                        sp_reg         <= ctx.sp - SP_STEP;
                        flags_push_reg <= retire.flags;
                        ret_reg        <= 1'b0;
                        ack_mode_reg   <= grant[PRI_MASKABLE_REQUEST_LINE];
                        step_due_reg   <= retire.flags[TF_BIT] && !grant[PRI_STEP];
                        state_reg      <= grant[PRI_MASKABLE_REQUEST_LINE] ? CIS_ACK1 : CIS_PUSH_F;
                    end
                end
                CIS_ACK1: begin
                    if (adv) begin
                        state_reg <= CIS_ACK2;
                    end
                end
                CIS_ACK2: begin
                    if (adv) begin
                        type_reg     <= bus_rdata[7:0];
                        ack_mode_reg <= 1'b0;
                        state_reg    <= CIS_PUSH_F;
                    end
                end
                CIS_PUSH_F: begin
                    if (adv) begin
                        sp_reg    <= sp_reg - SP_STEP;
                        state_reg <= CIS_PUSH_CS;
                    end
                end
                CIS_PUSH_CS: begin
                    if (adv) begin
                        sp_reg    <= sp_reg - SP_STEP;
                        state_reg <= CIS_PUSH_IP;
                    end
                end
                CIS_PUSH_IP: begin
                    if (adv) begin
                        flags_reg <= flags_push_reg & ~ENTRY_CLR;
                        state_reg <= CIS_VEC_LO;
                    end
                end
                CIS_VEC_LO: begin
                    if (adv) begin
                        ip_reg    <= bus_rdata;
                        state_reg <= CIS_VEC_HI;
                    end
                end
                CIS_VEC_HI: begin
                    if (adv) begin
                        cs_reg    <= bus_rdata;
                        state_reg <= CIS_LOAD;
                    end
                end
                CIS_LOAD: begin
                    ret_reg <= 1'b0;
                    // Chained entries push the fresh handler context
                    if (chain_nmi) begin
                        type_reg       <= TYPE_NMI;
                        flags_push_reg <= flags_reg;
                        sp_reg         <= sp_reg - SP_STEP;
                        state_reg      <= CIS_PUSH_F;
                    end else if (!ret_reg && step_due_reg) begin
                        type_reg       <= TYPE_STEP;
                        flags_push_reg <= flags_reg;
                        sp_reg         <= sp_reg - SP_STEP;
                        step_due_reg   <= 1'b0;
                        state_reg      <= CIS_PUSH_F;
                    end else begin
                        state_reg <= CIS_IDLE;
                    end
                end
                CIS_POP_IP: begin
                    if (adv) begin
                        ip_reg    <= bus_rdata;
                        sp_reg    <= sp_reg + SP_STEP;
                        state_reg <= CIS_POP_CS;
                    end
                end
                CIS_POP_CS: begin
                    if (adv) begin
                        cs_reg    <= bus_rdata;
                        sp_reg    <= sp_reg + SP_STEP;
                        state_reg <= CIS_POP_FL;
                    end
                end
                CIS_POP_FL: begin
                    if (adv) begin
                        flags_reg <= bus_rdata;
                        sp_reg    <= sp_reg + SP_STEP;
                        state_reg <= CIS_LOAD;
                    end
                end
                default: begin
                    state_reg <= CIS_IDLE;
                end
            endcase
        end
    end

    // ========================================
    // Bus issue
    // One idle cycle per access keeps every command field registered
    assign stack_addr = (20'(ss_reg) << SEG_SHIFT) + 20'(sp_reg);
    assign vec_addr   = 20'(type_reg) << VEC_SHIFT;
    assign need_bus   = (state_reg != CIS_IDLE) && (state_reg != CIS_LOAD);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            valid_reg <= 1'b0;
            cmd_reg   <= '0;
        end else if (adv) begin
            valid_reg <= 1'b0;
        end else if (!valid_reg && need_bus) begin
            valid_reg     <= 1'b1;
            cmd_reg.op    <= CIS_OP_RD;
            cmd_reg.addr  <= stack_addr;
            cmd_reg.wdata <= 16'h0000;
            unique case (state_reg)
                CIS_ACK1, CIS_ACK2: begin
                    cmd_reg.op   <= CIS_OP_ACK;
                    cmd_reg.addr <= 20'h00000;
                end
                CIS_PUSH_F: begin
                    cmd_reg.op    <= CIS_OP_WR;
                    cmd_reg.wdata <= flags_push_reg;
                end
                CIS_PUSH_CS: begin
                    cmd_reg.op    <= CIS_OP_WR;
                    cmd_reg.wdata <= cs_reg;
                end
                CIS_PUSH_IP: begin
                    cmd_reg.op    <= CIS_OP_WR;
                    cmd_reg.wdata <= ip_reg;
                end
                CIS_VEC_LO: begin
                    cmd_reg.addr <= vec_addr;
                end
                CIS_VEC_HI: begin
                    cmd_reg.addr <= vec_addr + WORD_BYTES;
                end
                default: begin
                    cmd_reg.addr <= stack_addr;
                end
            endcase
        end
    end

    assign bus_valid = valid_reg;
    assign bus_cmd   = cmd_reg;

    // ========================================
    // Redirect to the execution unit
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            redir_reg <= '0;
        end else begin
            redir_reg.load <= (state_reg == CIS_LOAD) && go_idle;
            if (state_reg == CIS_LOAD) begin
                redir_reg.ip    <= ip_reg;
                redir_reg.cs    <= cs_reg;
                redir_reg.sp    <= sp_reg;
                redir_reg.flags <= flags_reg;
            end
        end
    end

    assign redirect = redir_reg;

    // ========================================
    // Checks
    a_prefix_no_take: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_reg == CIS_IDLE && retire.done && retire.prefix) |=> (state_reg == CIS_IDLE))
        else $error("Interrupt taken after a prefix");

    a_seg_hold_all: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (boundary && retire.seg_load && !reqs[PRI_INT] && !retire.handler_return_instr) |=> (state_reg == CIS_IDLE))
        else $error("Interrupt taken after segment load");

    a_soft_int_type: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (full_end && retire.soft_int && !retire.div_ovf && !retire.handler_return_instr)
        |=> (state_reg == CIS_PUSH_F && type_reg == $past(retire.soft_type)))
        else $error("Software interrupt type wrong");

    a_div_err_type: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (full_end && retire.div_ovf && !retire.handler_return_instr) |=> (type_reg == TYPE_DIV))
        else $error("Divide error not type 0");

    a_into_clear_none: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (full_end && retire.into && !retire.flags[OF_BIT] && !retire.soft_int && !retire.div_ovf
         && !nmi_pend_reg && !maskable_request_line_s && !flags_reg[TF_BIT] && !retire.handler_return_instr)
        |=> (state_reg == CIS_IDLE))
        else $error("Overflow trap with flag clear");

    a_ack_only_maskable_request_line: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (valid_reg && cmd_reg.op == CIS_OP_ACK) |-> ack_mode_reg)
        else $error("Acknowledge cycle for internal source");

    a_vec_fetch_addr: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (valid_reg && state_reg == CIS_VEC_HI)
        |-> (cmd_reg.addr == {10'h000, type_reg, 2'h2} && cmd_reg.op == CIS_OP_RD))
        else $error("Vector address wrong");

    a_entry_clr_flags: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_reg == CIS_PUSH_IP && adv) |=> (flags_reg[TF_BIT] == 1'b0 && flags_reg[IF_BIT] == 1'b0)
        ##[1:1000] (state_reg == CIS_LOAD))
        else $error("Entry flags not cleared");

    a_nmi_sets_pend: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (nmi_s && !nmi_prev_reg) |=> nmi_pend_reg)
        else $error("Non-maskable edge lost");

    a_ret_sp_step: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_reg == CIS_POP_IP && adv) |=> (sp_reg == $past(sp_reg) + SP_STEP))
        else $error("Return stack step wrong");

endmodule

// File: verif/cis_partner.sv
// Bus unit, vector memory and interrupt controller model facing the sequencer
`timescale 1ns/1ps
module cis_partner import cis_pkg::*; (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        bus_valid,
    input  wire cis_bus_t    bus_cmd,
    output logic             bus_done,
    output logic      [15:0] bus_rdata,
    input  wire logic        req_go,
    input  wire logic [7:0]  req_type,
    output logic             maskable_request_line
);
    int   seed = 32'hca43;
    int   lat;
    logic ack_seen;
    // ========================================
    // Random latency keeps prompt and slow answers in play; idle data flips
    always @(posedge clk_sys) begin
        bus_done  <= 1'b0;
        bus_rdata <= ~bus_rdata;
        if (!reset_n) begin
            lat                   <= 0;
            ack_seen              <= 1'b0;
            bus_rdata             <= 16'h5a5a;
            maskable_request_line <= 1'b0;
        end else begin
            if (req_go) maskable_request_line <= 1'b1;
            if (bus_valid && !bus_done) begin
                if (lat == 0) begin
                    bus_done <= 1'b1;
                    lat      <= {$random(seed)} % 3;
                    if (bus_cmd.op == CIS_OP_ACK) begin
                        ack_seen <= !ack_seen;
                        if (ack_seen) begin
                            bus_rdata             <= {8'h00, req_type};
                            maskable_request_line <= 1'b0;
                        end
                    end else if (bus_cmd.op == CIS_OP_RD) begin
                        bus_rdata <= bus_cmd.addr[15:0] ^ 16'hc3a5;
                    end
                end else begin
                    lat <= lat - 1;
                end
            end
        end
    end
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the interrupt sequencer
`timescale 1ns/1ps
module tb_top import cis_pkg::*; ;
    localparam logic [7:0] K_NONE = 8'h00, K_PFX = 8'h80, K_STP = 8'h40, K_SEG = 8'h20, K_STI = 8'h10;
    localparam logic [7:0] K_RET = 8'h08, K_SWI = 8'h04, K_OVF = 8'h02, K_DIV = 8'h01;
    logic          clk_sys, reset_n, maskable_request_line, nmi_line, busy, bus_valid, bus_done, req_go;
    logic [15:0]   bus_rdata;
    logic [7:0]    req_type;
    cis_retire_t   retire;
    cis_ctx_t      ctx;
    cis_bus_t      bus_cmd;
    cis_redirect_t redirect;
    cis_bus_t      exp_bus[$];
    cis_redirect_t exp_rd[$];
    int            seed = 32'hca43;
    int            bad_count = 0;
    int            n_checks = 0;
    cis_seq u_cis_seq (.clk_sys(clk_sys), .reset_n(reset_n), .retire(retire), .ctx(ctx),
        .maskable_request_line(maskable_request_line), .nmi_line(nmi_line), .busy(busy), .bus_valid(bus_valid),
        .bus_cmd(bus_cmd), .bus_done(bus_done), .bus_rdata(bus_rdata), .redirect(redirect));
    cis_partner u_cis_partner (.clk_sys(clk_sys), .reset_n(reset_n), .bus_valid(bus_valid), .bus_cmd(bus_cmd),
        .bus_done(bus_done), .bus_rdata(bus_rdata), .req_go(req_go), .req_type(req_type),
        .maskable_request_line(maskable_request_line));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // ========================================
    // Compare tasks and expectation builders
    task automatic cmp_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bus(input cis_bus_t got, input cis_bus_t exp);
        n_checks++;
        if (got.op !== exp.op || got.addr !== exp.addr || (exp.op == CIS_OP_WR && got.wdata !== exp.wdata)) begin
            bad_count++;
            $display("unexpected bus at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_rd(input cis_redirect_t got, input cis_redirect_t exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected redirect at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] vec(input logic [19:0] a);
        return a[15:0] ^ 16'hc3a5;
    endfunction
    task automatic exp_entry(input logic [7:0] t, input logic [15:0] fl, cs, ss, sp, ip, input logic ak, last);
        logic [19:0] base;
        logic [19:0] va;
        base = {ss, 4'h0};
        va   = {10'h000, t, 2'b00};
        if (ak) begin
            exp_bus.push_back('{CIS_OP_ACK, 20'h00000, 16'h0000});
            exp_bus.push_back('{CIS_OP_ACK, 20'h00000, 16'h0000});
        end
        exp_bus.push_back('{CIS_OP_WR, base + {4'h0, sp - 16'h0002}, fl});
        exp_bus.push_back('{CIS_OP_WR, base + {4'h0, sp - 16'h0004}, cs});
        exp_bus.push_back('{CIS_OP_WR, base + {4'h0, sp - 16'h0006}, ip});
        exp_bus.push_back('{CIS_OP_RD, va, 16'h0000});
        exp_bus.push_back('{CIS_OP_RD, va + WORD_BYTES, 16'h0000});
        if (last) exp_rd.push_back('{1'b1, vec(va), vec(va + WORD_BYTES), sp - 16'h0006, fl & ~ENTRY_CLR});
    endtask
    // Mode: 0 none, 1 internal or non-maskable, 2 maskable, 3 chained non-maskable, 4 return, 5 chained step
    task automatic go(input string nm, input logic [7:0] k, t, input logic [15:0] fl, input int mode);
        cis_ctx_t    c;
        logic [15:0] nip;
        logic [19:0] a;
        int          i;
        c   = {16'($random(seed)), 16'($random(seed)), (16'($random(seed)) & 16'h7ffe) | 16'h0100};
        nip = 16'($random(seed));
        a   = {c.ss, 4'h0} + {4'h0, c.sp};
        case (mode)
            1, 2: exp_entry(t, fl, c.cs, c.ss, c.sp, nip, mode == 2, 1'b1);
            3, 5: begin
                exp_entry(t, fl, c.cs, c.ss, c.sp, nip, 1'b0, 1'b0);
                exp_entry(mode == 3 ? TYPE_NMI : TYPE_STEP, fl & ~ENTRY_CLR, vec({10'h000, t, 2'b10}), c.ss,
                          c.sp - 16'h0006,
                          vec({10'h000, t, 2'b00}), 1'b0, 1'b1);
            end
            4: begin
                for (i = 0; i < 3; i++) exp_bus.push_back('{CIS_OP_RD, a + 20'(2 * i), 16'h0000});
                exp_rd.push_back('{1'b1, vec(a), vec(a + 20'h2), c.sp + 16'h0006, vec(a + 20'h4)});
            end
            default: ;
        endcase
        @(posedge clk_sys);
        #1 retire = {1'b1, k, t, nip, fl};
        ctx = c;
        #1 cmp_bit(busy, mode != 0);
        @(posedge clk_sys);
        #1 retire = '0;
        for (i = 0; i < 300 && busy !== 1'b0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (i == 300) bad_count++;
        repeat (3) @(posedge clk_sys);
        #1 cmp_bit(exp_bus.size() == 0 && exp_rd.size() == 0, 1'b1);
        $display("test %s done", nm);
    endtask
    // ========================================
    // Output watcher takes the oldest note for each result
    always @(posedge clk_sys) begin
        if (reset_n && bus_valid && bus_done) cmp_bus(bus_cmd, exp_bus.size() > 0 ? exp_bus.pop_front() : '0);
        if (reset_n && redirect.load) cmp_rd(redirect, exp_rd.size() > 0 ? exp_rd.pop_front() : '0);
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        $display("test watchdog expired");
        print_verdict();
    end
    initial begin
        retire   = '0;
        ctx      = '0;
        nmi_line = 1'b0;
        req_go   = 1'b0;
        req_type = 8'h00;
        reset_n  = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        go("divide", K_DIV, TYPE_DIV, 16'($random(seed)) & 16'hf4ff, 1);
        for (int j = 0; j < 3; j++) go("soft", K_SWI, 8'($random(seed)), 16'h0000, 1);
        go("ovf_clear", K_OVF, TYPE_OVF, 16'h0000, 0);
        go("ovf_set", K_OVF, TYPE_OVF, 16'h0800, 1);
        go("step_set", K_NONE, TYPE_STEP, TF_MASK, 0);
        go("step_trap", K_NONE, TYPE_STEP, 16'h0000, 1);
        req_type = 8'($random(seed));
        req_go   = 1'b1;
        @(posedge clk_sys);
        #1 req_go = 1'b0;
        repeat (4) @(posedge clk_sys);
        go("sti", K_STI, req_type, 16'h0200, 0);
        go("prefix", K_PFX, req_type, 16'h0200, 0);
        go("seg_load", K_SEG, req_type, 16'h0200, 0);
        go("maskable", K_NONE, req_type, 16'h0200, 2);
        nmi_line = 1'b1;
        repeat (4) @(posedge clk_sys);
        go("nmi_mid", K_STP, TYPE_NMI, 16'h0000, 1);
        nmi_line = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 nmi_line = 1'b1;
        repeat (4) @(posedge clk_sys);
        go("divide_nmi", K_DIV, TYPE_DIV, 16'h0000, 3);
        nmi_line = 1'b0;
        go("step_chain", K_SWI, 8'($random(seed)), TF_MASK, 5);
        go("return", K_RET, 8'h00, 16'h0000, 4);
        print_verdict();
    end
endmodule
